// >>> verilog/mcc_pkg.sv
// package for the main contactor control block
package mcc_pkg;
    // register byte offsets
    localparam logic [11:0] ADDR_CTRL   = 12'h000;
    localparam logic [11:0] ADDR_DELAY  = 12'h004;
    localparam logic [11:0] ADDR_STATUS = 12'h008;
    localparam logic [11:0] ADDR_INPUT  = 12'h00C;
    // field positions
    localparam int CTRL_ACK_EN     = 0;
    localparam int CTRL_SEL_LO     = 1;
    localparam int IN_REQ_BIT      = 5;
    localparam int OUT_RELAY_BIT   = 0;
    localparam int ST_RELAY        = 0;
    localparam int ST_COUNTING     = 1;
    localparam int ST_ACK          = 2;
    localparam int ST_DONE         = 3;
    // reset values
    localparam logic [15:0] DELAY_MS_RESET = 16'h2710;
    localparam logic [2:0]  CTRL_RESET     = 3'h0;
    // timing
    localparam int CLK_HZ       = 40000000;
    localparam int MS_PER_S     = 1000;
    localparam int CYC_PER_MS   = CLK_HZ / MS_PER_S;
    // state of the contactor sequencer
    typedef enum logic [3:0] {
        MCC_OPEN    = 4'h1,
        MCC_CLOSED  = 4'h2,
        MCC_EXTRUN  = 4'h4,
        MCC_DELAY   = 4'h8
    } mcc_state_t;
    // drive status carrier
    typedef struct packed {
        logic running;
        logic stop_cmd;
        logic ext_run;
        logic start_cmd;
    } mcc_drive_t;
endpackage

// >>> verilog/mcc_ms_tick.sv
// millisecond enable divider
`timescale 1ns/10ps
module mcc_ms_tick #(
    parameter int DIV = mcc_pkg::CYC_PER_MS
) (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // control
    input  wire logic clear,
    output logic      tick
);
    logic [15:0] cnt;
    logic [15:0] next_cnt;

    always_comb begin
        if (clear || cnt == 16'(DIV - 1)) begin
            next_cnt = 16'h0000;
        end else begin
            next_cnt = cnt + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 16'h0000;
        end else begin
            cnt <= next_cnt;
        end
    end

    assign tick = !clear && cnt == 16'(DIV - 1);
endmodule

// >>> verilog/mcc_top.sv
// main contactor control with apb registers
// Notes on behaviour
// - rising edge on request input closes the contactor
// - falling edge on request input opens the contactor
// - auto-open delay programmable in milliseconds, default 10000 ms
// - auto-open only after stop and stopped, extended run over, delay elapsed
// - relay output bit 0 high means close, low means open
// - falling edge opens at once, abandoning any running delay
// - optional power acknowledge input confirms contactor closed
`timescale 1ns/10ps
module mcc_top #(
    parameter int MS_DIV = mcc_pkg::CYC_PER_MS
) (
    // clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // digital inputs and drive state
    input  wire logic [7:0]        digital_inputs,
    input  wire logic              power_ack_input,
    input  wire mcc_pkg::mcc_drive_t drive,
    // outputs
    output logic      [7:0]        relay_output_word,
    output logic                   contactor_confirmed
);
    // register state
    logic [2:0]  ctrl;
    logic [2:0]  next_ctrl;
    logic [15:0] delay_ms;
    logic [15:0] next_delay_ms;
    // sequencer state
    mcc_pkg::mcc_state_t state;
    mcc_pkg::mcc_state_t next_state;
    logic [15:0] ms_cnt;
    logic [15:0] next_ms_cnt;
    logic        req_q;
    logic        done;
    logic        next_done;
    logic        relay;
    logic        next_relay;
    logic        tick;
    logic        req_now;
    logic        rise;
    logic        fall;
    logic        wr_en;
    logic        in_delay;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        hit = a == off;
    endfunction

    // power-ack selector: bit 0 enables, bits 2:1 choose ack source
    assign req_now  = digital_inputs[mcc_pkg::IN_REQ_BIT];
    assign rise     = req_now && !req_q;
    assign fall     = !req_now && req_q;
    assign in_delay = state == mcc_pkg::MCC_DELAY;
    assign wr_en    = psel && penable && pwrite;

    mcc_ms_tick #(
        .DIV (MS_DIV)
    ) u_tick (
        .pclk    (pclk),
        .presetn (presetn),
        .clear   (!in_delay),
        .tick    (tick)
    );

    // register writes
    always_comb begin
        next_ctrl     = ctrl;
        next_delay_ms = delay_ms;
        if (wr_en && hit(paddr, mcc_pkg::ADDR_CTRL)) begin
            next_ctrl = pwdata[2:0];
        end
        if (wr_en && hit(paddr, mcc_pkg::ADDR_DELAY)) begin
            next_delay_ms = pwdata[15:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl     <= mcc_pkg::CTRL_RESET;
            delay_ms <= mcc_pkg::DELAY_MS_RESET;
        end else begin
            ctrl     <= next_ctrl;
            delay_ms <= next_delay_ms;
        end
    end

    // contactor sequencer
    always_comb begin
        next_state  = state;
        next_ms_cnt = ms_cnt;
        next_relay  = relay;
        next_done   = done;
        case (state)
            mcc_pkg::MCC_OPEN: begin
                next_relay = 1'b0;
                if (rise) begin
                    next_state = mcc_pkg::MCC_CLOSED;
                    next_relay = 1'b1;
                    next_done  = 1'b0;
                end
            end
            mcc_pkg::MCC_CLOSED: begin
                if (drive.stop_cmd && !drive.running) begin
                    next_state = mcc_pkg::MCC_EXTRUN;
                end
            end
            mcc_pkg::MCC_EXTRUN: begin
                if (drive.start_cmd || drive.running) begin
                    next_state = mcc_pkg::MCC_CLOSED;
                end else if (!drive.ext_run) begin
                    next_state  = mcc_pkg::MCC_DELAY;
                    next_ms_cnt = 16'h0000;
                end
            end
            mcc_pkg::MCC_DELAY: begin
                if (drive.start_cmd || drive.running) begin
                    next_state = mcc_pkg::MCC_CLOSED;
                end else if (ms_cnt >= delay_ms) begin
                    next_state = mcc_pkg::MCC_OPEN;
                    next_relay = 1'b0;
                    next_done  = 1'b1;
                end else if (tick) begin
                    next_ms_cnt = ms_cnt + 16'h0001;
                end
            end
            default: begin
                next_state = mcc_pkg::MCC_OPEN;
                next_relay = 1'b0;
            end
        endcase
        if (fall) begin
            next_state = mcc_pkg::MCC_OPEN;
            next_relay = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state  <= mcc_pkg::MCC_OPEN;
            ms_cnt <= 16'h0000;
            req_q  <= 1'b0;
            relay  <= 1'b0;
            done   <= 1'b0;
        end else begin
            state  <= next_state;
            ms_cnt <= next_ms_cnt;
            req_q  <= req_now;
            relay  <= next_relay;
            done   <= next_done;
        end
    end

    // outputs
    logic ack_src;
    always_comb begin
        case (ctrl[2:1])
            2'h0:    ack_src = power_ack_input;
            2'h1:    ack_src = digital_inputs[0];
            2'h2:    ack_src = digital_inputs[1];
            default: ack_src = digital_inputs[2];
        endcase
    end

    assign relay_output_word   = {7'h00, relay};
    assign contactor_confirmed = relay && (!ctrl[mcc_pkg::CTRL_ACK_EN] || ack_src);

    // apb read path, zero wait states
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !(hit(paddr, mcc_pkg::ADDR_CTRL) || hit(paddr, mcc_pkg::ADDR_DELAY)
                     || hit(paddr, mcc_pkg::ADDR_STATUS) || hit(paddr, mcc_pkg::ADDR_INPUT));
    always_comb begin
        prdata = 32'h0000_0000;
        if (hit(paddr, mcc_pkg::ADDR_CTRL)) begin
            prdata = {29'h0, ctrl};
        end else if (hit(paddr, mcc_pkg::ADDR_DELAY)) begin
            prdata = {16'h0, delay_ms};
        end else if (hit(paddr, mcc_pkg::ADDR_STATUS)) begin
            prdata = {28'h0, done, contactor_confirmed, in_delay, relay};
        end else if (hit(paddr, mcc_pkg::ADDR_INPUT)) begin
            prdata = {16'h0, ms_cnt};
        end
    end

    // checks
    property p_rise_close;
        @(posedge pclk) disable iff (!presetn) rise && !fall |=> relay;
    endproperty
    a_rise_close: assert property (p_rise_close) else $error("rising request did not close");

    property p_fall_open;
        @(posedge pclk) disable iff (!presetn) fall |=> !relay && state == mcc_pkg::MCC_OPEN;
    endproperty
    a_fall_open: assert property (p_fall_open) else $error("falling request did not open");

    property p_open_needs_cause;
        @(posedge pclk) disable iff (!presetn) $fell(relay) |-> $past(fall) || $past(in_delay);
    endproperty
    a_open_needs_cause: assert property (p_open_needs_cause) else $error("relay opened without cause");

    property p_close_needs_rise;
        @(posedge pclk) disable iff (!presetn) $rose(relay) |-> $past(rise);
    endproperty
    a_close_needs_rise: assert property (p_close_needs_rise) else $error("relay closed without edge");

    property p_start_cancels;
        @(posedge pclk) disable iff (!presetn) in_delay && drive.start_cmd && !fall |=> relay && !in_delay;
    endproperty
    a_start_cancels: assert property (p_start_cancels) else $error("start did not cancel delay");

    property p_delay_count;
        @(posedge pclk) disable iff (!presetn) in_delay && ms_cnt < delay_ms && !fall |=> relay;
    endproperty
    a_delay_count: assert property (p_delay_count) else $error("opened before delay elapsed");

    property p_out_bit;
        @(posedge pclk) disable iff (!presetn) relay_output_word[mcc_pkg::OUT_RELAY_BIT] == relay
            && relay_output_word[7:1] == 7'h00;
    endproperty
    a_out_bit: assert property (p_out_bit) else $error("relay bit misplaced");

    property p_ack;
        @(posedge pclk) disable iff (!presetn) contactor_confirmed |-> relay;
    endproperty
    a_ack: assert property (p_ack) else $error("confirm without closed relay");
endmodule

// >>> verification/mcc_contactor_model.sv
// contactor relay model with acknowledge contact
`timescale 1ns/10ps
module mcc_contactor_model (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // coil and contact
    input  wire logic coil,
    input  wire logic slow,
    output logic      ack
);
    logic [3:0] lag;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lag <= 4'h0;
            ack <= 1'b0;
        end else if (!coil) begin
            lag <= 4'h0;
            ack <= 1'b0;
        end else begin
            lag <= lag + ((lag == 4'hF) ? 4'h0 : 4'h1);
            ack <= (lag >= (slow ? 4'h8 : 4'h2));
        end
    end
endmodule

// >>> verification/main_contactor_control_test.sv
// self-checking bench for main contactor control
`timescale 1ns/10ps
module main_contactor_control_test;
    localparam int DIV = 4;
    logic                pclk      = 1'b0;
    logic                presetn   = 1'b0;
    logic                psel      = 1'b0;
    logic                penable   = 1'b0;
    logic                pwrite    = 1'b0;
    logic                slow      = 1'b0;
    logic [11:0]         paddr     = 12'h000;
    logic [31:0]         pwdata    = 32'h0;
    logic [7:0]          din       = 8'h00;
    logic [7:0]          last_rel  = 8'h00;
    mcc_pkg::mcc_drive_t drive     = '0;
    logic [31:0]         prdata;
    logic [7:0]          relay;
    logic                pready;
    logic                pslverr;
    logic                ack;
    logic                confirmed;
    logic [32:0]         e;
    logic [7:0]          rel_q[$];
    logic [32:0]         rd_q[$];
    int                  err_total = 0;
    int                  checked   = 0;
    int                  seed      = 32'h1083;
    int                  d;

    always #12.5 pclk = ~pclk;

    mcc_top #(.MS_DIV(DIV)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .digital_inputs(din), .power_ack_input(ack), .drive(drive),
        .relay_output_word(relay), .contactor_confirmed(confirmed));
    mcc_contactor_model relay_model (.pclk(pclk), .presetn(presetn), .coil(relay[0]), .slow(slow), .ack(ack));

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic fail(input string what);
        err_total++;
        $display("Error at %0t: %s", $time, what);
        give_verdict();
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) fail("pready timeout");
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        rd_q.push_back({1'b0, exp});
        apb(1'b0, a, 32'h0);
    endtask

    task automatic set_req(input logic b);
        logic [31:0] r;
        @(posedge pclk);
        r = $random(seed);
        din <= {r[7:6], b, r[4:0]};
    endtask

    task automatic wait_done(input int lo, input int hi);
        int n;
        n = 0;
        while (rel_q.size() > 0 && n <= hi) begin
            @(posedge pclk);
            n++;
        end
        if (n < lo || n > hi) fail("relay timing");
    endtask

    // result monitor
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && rd_q.size() > 0) begin
            e = rd_q.pop_front();
            if (e[32]) cmp(pslverr, 1'b1, "slverr");
            else cmp(prdata, e[31:0], "rdata");
        end
        if (presetn && relay !== last_rel) begin
            if (rel_q.size() == 0) cmp(relay, last_rel, "relay unexpected");
            else cmp(relay, rel_q.pop_front(), "relay");
        end
        last_rel = relay;
    end

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        set_req(1'b0);
        repeat (4) @(posedge pclk);
        cmp(relay, 8'h00, "reset relay");
        rd(mcc_pkg::ADDR_DELAY, {16'h0, mcc_pkg::DELAY_MS_RESET});
        rd(mcc_pkg::ADDR_CTRL, 32'h0);
        rd_q.push_back({1'b1, 32'h0});
        apb(1'b0, 12'h010, 32'h0);
        d = 2 + ($unsigned($random(seed)) % 3);
        apb(1'b1, mcc_pkg::ADDR_DELAY, d);
        apb(1'b1, mcc_pkg::ADDR_CTRL, 32'h1);
        $display("test registers done");
        rel_q.push_back(8'h01);
        set_req(1'b1);
        wait_done(0, 5);
        drive.start_cmd <= 1'b1;
        drive.running <= 1'b1;
        repeat (12) @(posedge pclk);
        cmp(confirmed, 1'b1, "confirm");
        drive <= 4'b0110;
        repeat (30) @(posedge pclk);
        cmp(relay, 8'h01, "ext run hold");
        rel_q.push_back(8'h00);
        drive.ext_run <= 1'b0;
        wait_done((d - 1) * DIV, d * DIV + 8);
        rd(mcc_pkg::ADDR_STATUS, 32'h8);
        rd(mcc_pkg::ADDR_INPUT, d);
        $display("test auto open done");
        slow <= 1'b1;
        set_req(1'b0);
        rel_q.push_back(8'h01);
        set_req(1'b1);
        wait_done(0, 5);
        drive <= 4'b0100;
        repeat (6) @(posedge pclk);
        drive <= 4'b0001;
        repeat (d * DIV + 12) @(posedge pclk);
        cmp(relay, 8'h01, "restart hold");
        rd(mcc_pkg::ADDR_STATUS, 32'h5);
        for (int s = 1; s < 4; s++) begin
            apb(1'b1, mcc_pkg::ADDR_CTRL, {29'h0, 2'(s), 1'b1});
            @(posedge pclk);
            cmp(confirmed, din[s - 1], "ack source");
        end
        apb(1'b1, mcc_pkg::ADDR_CTRL, 32'h1);
        drive <= 4'b0100;
        repeat (6) @(posedge pclk);
        rel_q.push_back(8'h00);
        set_req(1'b0);
        wait_done(0, 3);
        rd(mcc_pkg::ADDR_DELAY, d);
        $display("test manual open done");
        give_verdict();
    end
endmodule
